// ---- pbsp_pkg.sv ----
// Package for the pipelined burst SRAM port: widths, field layout, carriers.
// Assumes nothing of its surroundings; used by the port and its test access module.
package pbsp_pkg;
  localparam int ADDR_W = 17;
  localparam int BYTE_W = 9;
  localparam int NUM_BYTES = 4;
  localparam int WORD_W = 36;
  localparam int DATA_BITS_W = 32;
  localparam int EXTRA_W = 4;
  localparam int DEPTH = 131072;
  localparam int BURST_W = 2;
  localparam int IR_W = 4;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  // Arbitrary identification value, not a real maker code
  localparam logic [31:0] ID_VALUE = 32'h00000001;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [NUM_BYTES-1:0] byte_write_select_n;
  } pbsp_op_t;

  typedef struct packed {
    logic chip_select_low_a_n;
    logic chip_select_low_b_n;
    logic chip_select_pair_other;
  } pbsp_sel_t;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
    UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } pbsp_tap_t;
endpackage : pbsp_pkg

// ---- pbsp_tap.sv ----
// Boundary test access port: state controller, instruction, bypass and ID register.
// Assumes the test clock and test reset arrive from pins; it runs wholly on the test clock.
`timescale 1ns/100ps
`default_nettype none
module pbsp_tap (
  // Test pins
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o
);
  pbsp_pkg::pbsp_tap_t state_q, state_d;
  logic [pbsp_pkg::IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
  logic [31:0] dr_q, dr_d;
  logic tdo_q, tdo_d, oe_q, oe_d;
  logic shifting;

  always_comb begin
    state_d = state_q;
    case (state_q)
      pbsp_pkg::TEST_LOGIC_RESET: state_d = tms_i ? pbsp_pkg::TEST_LOGIC_RESET : pbsp_pkg::RUN_IDLE;
      pbsp_pkg::RUN_IDLE: state_d = tms_i ? pbsp_pkg::SEL_DR : pbsp_pkg::RUN_IDLE;
      pbsp_pkg::SEL_DR: state_d = tms_i ? pbsp_pkg::SEL_IR : pbsp_pkg::CAP_DR;
      pbsp_pkg::CAP_DR: state_d = tms_i ? pbsp_pkg::EXIT1_DR : pbsp_pkg::SHIFT_DR;
      pbsp_pkg::SHIFT_DR: state_d = tms_i ? pbsp_pkg::EXIT1_DR : pbsp_pkg::SHIFT_DR;
      pbsp_pkg::EXIT1_DR: state_d = tms_i ? pbsp_pkg::UPD_DR : pbsp_pkg::PAUSE_DR;
      pbsp_pkg::PAUSE_DR: state_d = tms_i ? pbsp_pkg::EXIT2_DR : pbsp_pkg::PAUSE_DR;
      pbsp_pkg::EXIT2_DR: state_d = tms_i ? pbsp_pkg::UPD_DR : pbsp_pkg::SHIFT_DR;
      pbsp_pkg::UPD_DR: state_d = tms_i ? pbsp_pkg::SEL_DR : pbsp_pkg::RUN_IDLE;
      pbsp_pkg::SEL_IR: state_d = tms_i ? pbsp_pkg::TEST_LOGIC_RESET : pbsp_pkg::CAP_IR;
      pbsp_pkg::CAP_IR: state_d = tms_i ? pbsp_pkg::EXIT1_IR : pbsp_pkg::SHIFT_IR;
      pbsp_pkg::SHIFT_IR: state_d = tms_i ? pbsp_pkg::EXIT1_IR : pbsp_pkg::SHIFT_IR;
      pbsp_pkg::EXIT1_IR: state_d = tms_i ? pbsp_pkg::UPD_IR : pbsp_pkg::PAUSE_IR;
      pbsp_pkg::PAUSE_IR: state_d = tms_i ? pbsp_pkg::EXIT2_IR : pbsp_pkg::PAUSE_IR;
      pbsp_pkg::EXIT2_IR: state_d = tms_i ? pbsp_pkg::UPD_IR : pbsp_pkg::SHIFT_IR;
      pbsp_pkg::UPD_IR: state_d = tms_i ? pbsp_pkg::SEL_DR : pbsp_pkg::RUN_IDLE;
      default: state_d = pbsp_pkg::TEST_LOGIC_RESET;
    endcase
  end

  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    dr_d = dr_q;
    case (state_q)
      pbsp_pkg::TEST_LOGIC_RESET: ir_d = pbsp_pkg::IR_IDCODE;
      pbsp_pkg::CAP_IR: ir_sh_d = pbsp_pkg::IR_CAPTURE;
      pbsp_pkg::SHIFT_IR: ir_sh_d = {tdi_i, ir_sh_q[pbsp_pkg::IR_W-1:1]};
      pbsp_pkg::UPD_IR: ir_d = ir_sh_q;
      pbsp_pkg::CAP_DR: dr_d = (ir_q == pbsp_pkg::IR_IDCODE) ? pbsp_pkg::ID_VALUE : 32'h00000000;
      pbsp_pkg::SHIFT_DR: begin
        if (ir_q == pbsp_pkg::IR_IDCODE) begin
          dr_d = {tdi_i, dr_q[31:1]};
        end else begin
          dr_d = {31'h00000000, tdi_i};
        end
      end
      default: ;
    endcase
  end

  // Capture on rising edge; power-up, five-TMS-high, and test reset all return here [R16] [R18]
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      state_q <= pbsp_pkg::TEST_LOGIC_RESET; // [R18]
      ir_sh_q <= '0;
      ir_q <= pbsp_pkg::IR_IDCODE;
      dr_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
      dr_q <= dr_d;
    end
  end

  assign shifting = (state_q == pbsp_pkg::SHIFT_DR) || (state_q == pbsp_pkg::SHIFT_IR);

  always_comb begin
    oe_d = shifting; // [R17]
    tdo_d = (state_q == pbsp_pkg::SHIFT_IR) ? ir_sh_q[0] : dr_q[0];
  end

  // Output changes on the falling edge [R16]
  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
      oe_q <= oe_d;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_o = oe_q; // [R17]
endmodule : pbsp_tap
`default_nettype wire

// ---- pbsp_port.sv ----
// Pipelined burst SRAM port: pipelined control, burst counter, byte-masked array.
// Assumes all synchronous inputs are produced on clk_i by the controller; test pins are separate.
`timescale 1ns/100ps
`default_nettype none
// Function
// [R1] Words split into four 9-bit byte lanes
// [R2] Controller gives byte selects on write loads
// [R3] Controller gives byte selects on burst advances
// [R4] Byte selects ignored on read cycles
// [R5] Enabled bytes written two cycles later
// [R6] Selects may be tied low for full words
// [R7] Load with any select inactive deselects
// [R8] Bus floats two cycles after deselect
// [R9] High select equals low selects, inverted
// [R10] All timing on rising clock except output enable
// [R11] Write and read data registered
// [R12] High order input selects interleaved burst
// [R13] Burst order input held static
// [R14] Read data driven only while enable low
// [R15] Output enable may be tied low
// [R16] Test inputs rise-sampled, output falls-changed
// [R17] Test output enabled only while shifting
// [R18] Test controller reset power-up, sequence, pin
// [R19] Sleep gates clock, keeps contents
// [R20] Clock gate high freezes everything
// [R21] Load takes address, advance steps counter
// [R22] Deselecting load ends any burst
// [R23] Data on bus two cycles after load
// [R24] Four-word counter, linear add or XOR
// [R25] Reads and writes alternate back to back
module pbsp_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clock_gate_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_select_n_i,
  input wire logic advance_or_load_i,
  input wire logic read_write_n_i,
  input wire pbsp_pkg::pbsp_sel_t select_i,
  input wire logic [pbsp_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pbsp_pkg::NUM_BYTES-1:0] byte_write_select_n_i,
  input wire logic output_enable_n_i,
  // Data pins
  input wire logic [pbsp_pkg::DATA_BITS_W-1:0] data_bits_i,
  input wire logic [pbsp_pkg::EXTRA_W-1:0] byte_extra_bits_i,
  output logic [pbsp_pkg::DATA_BITS_W-1:0] data_bits_o,
  output logic [pbsp_pkg::EXTRA_W-1:0] byte_extra_bits_o,
  output logic data_oe_o,
  // Test access
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o
);
  logic [pbsp_pkg::WORD_W-1:0] mem_q [pbsp_pkg::DEPTH];
  pbsp_pkg::pbsp_op_t op1_q, op1_d, op2_q, op2_d;
  logic [pbsp_pkg::ADDR_W-1:0] base_q, base_d;
  logic [pbsp_pkg::BURST_W-1:0] cnt_q, cnt_d, step;
  logic burst_q, burst_d, wr_q, wr_d, order_q, order_d;
  logic [pbsp_pkg::WORD_W-1:0] rd_q, rd_d, win;
  logic rd_vld_q, rd_vld_d;
  logic active, selected, wr_go;

  // Sleep and clock gate both make the edge a no-op [R19] [R20]
  assign active = !clock_gate_n_i && !sleep_request_i;
  // All three selects must be asserted [R9] [R7]
  assign selected = !select_i.chip_select_low_a_n && !select_i.chip_select_low_b_n &&
                    select_i.chip_select_pair_other;
  // Pack each pin lane as its extra bit above its eight data bits [R1]
  always_comb begin
    win = '0;
    for (int b = 0; b < pbsp_pkg::NUM_BYTES; b++) begin
      win[b*pbsp_pkg::BYTE_W +: pbsp_pkg::BYTE_W] =
        {byte_extra_bits_i[b], data_bits_i[b*(pbsp_pkg::BYTE_W-1) +: pbsp_pkg::BYTE_W-1]};
    end
  end

  // Burst step: counter adds one modulo four in both orders; the address applies add or XOR [R24] [R12]
  always_comb begin
    step = cnt_q + 2'h1;
    if (order_q) begin
      step = cnt_q + 2'h1;
    end
  end

  always_comb begin
    op1_d = op1_q;
    op2_d = op2_q;
    base_d = base_q;
    cnt_d = cnt_q;
    burst_d = burst_q;
    wr_d = wr_q;
    order_d = order_q;
    if (active) begin
      op2_d = op1_q;
      op1_d = '0;
      if (!advance_or_load_i) begin
        if (selected) begin
          // New address and control [R21]
          base_d = addr_i;
          cnt_d = '0;
          burst_d = 1'b1;
          wr_d = !read_write_n_i;
          order_d = burst_order_select_n_i;
          op1_d.valid = 1'b1;
          op1_d.write = !read_write_n_i;
          op1_d.addr = addr_i;
          // Selects only matter on writes [R4]
          op1_d.byte_write_select_n = read_write_n_i ? {pbsp_pkg::NUM_BYTES{1'b1}}
                                                     : byte_write_select_n_i;
        end else begin
          burst_d = 1'b0; // [R22] [R7]
        end
      end else if (burst_q) begin
        // Advance ignores external address [R21] [R24]
        cnt_d = step;
        op1_d.valid = 1'b1;
        op1_d.write = wr_q;
        if (order_q) begin
          op1_d.addr = {base_q[pbsp_pkg::ADDR_W-1:pbsp_pkg::BURST_W],
                        base_q[pbsp_pkg::BURST_W-1:0] ^ step}; // [R12]
        end else begin
          op1_d.addr = {base_q[pbsp_pkg::ADDR_W-1:pbsp_pkg::BURST_W],
                        base_q[pbsp_pkg::BURST_W-1:0] + step}; // [R12]
        end
        op1_d.byte_write_select_n = wr_q ? byte_write_select_n_i
                                         : {pbsp_pkg::NUM_BYTES{1'b1}}; // [R3] [R4]
      end
    end
  end

  // A write still in the pipe is dropped by reset rather than landing
  assign wr_go = rst_n_i && active && op2_q.valid && op2_q.write;

  // Registered data paths [R11]
  always_comb begin
    rd_d = rd_q;
    rd_vld_d = rd_vld_q;
    if (active) begin
      // Read word appears two edges after its load [R23] [R25]
      rd_vld_d = op2_q.valid && !op2_q.write;
      if (op2_q.valid && !op2_q.write) begin
        rd_d = mem_q[op2_q.addr];
      end
    end
  end

  always_ff @(posedge clk_i) begin // [R10]
    if (!rst_n_i) begin
      op1_q <= '0;
      op2_q <= '0;
      base_q <= '0;
      cnt_q <= '0;
      burst_q <= 1'b0;
      wr_q <= 1'b0;
      order_q <= 1'b0;
      rd_q <= '0;
      rd_vld_q <= 1'b0;
    end else begin
      op1_q <= op1_d;
      op2_q <= op2_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
      burst_q <= burst_d;
      wr_q <= wr_d;
      order_q <= order_d;
      rd_q <= rd_d;
      rd_vld_q <= rd_vld_d;
    end
  end

  // Array has no reset: contents survive reset and sleep [R19]
  // Write data sampled in the second pipeline cycle, stored by its byte lanes [R5] [R1] [R25]
  // One process owns the array, so every lane is written from the same place
  always_ff @(posedge clk_i) begin
    for (int b = 0; b < pbsp_pkg::NUM_BYTES; b++) begin
      if (wr_go && !op2_q.byte_write_select_n[b]) begin
        mem_q[op2_q.addr][b*pbsp_pkg::BYTE_W +: pbsp_pkg::BYTE_W] <=
          win[b*pbsp_pkg::BYTE_W +: pbsp_pkg::BYTE_W]; // [R1] [R5]
      end
    end
  end

  // Lane mapping: lane b = 8 data bits plus one extra bit
  always_comb begin
    data_bits_o = '0;
    byte_extra_bits_o = '0;
    for (int b = 0; b < pbsp_pkg::NUM_BYTES; b++) begin
      data_bits_o[b*(pbsp_pkg::BYTE_W-1) +: pbsp_pkg::BYTE_W-1] =
        rd_q[b*pbsp_pkg::BYTE_W +: pbsp_pkg::BYTE_W-1];
      byte_extra_bits_o[b] = rd_q[b*pbsp_pkg::BYTE_W + pbsp_pkg::BYTE_W-1];
    end
  end

  // Drive only for a read word and while enable low; floats after deselect [R14] [R8]
  assign data_oe_o = rd_vld_q && !output_enable_n_i; // [R14] [R8]

  pbsp_tap u_tap (
    .tck_i(tck_i),
    .trst_n_i(trst_n_i),
    .tms_i(tms_i),
    .tdi_i(tdi_i),
    .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o)
  );
endmodule : pbsp_port
`default_nettype wire

// ---- pbsp_port_props.sv ----
// Checker for the burst SRAM port: latency, floating, freeze and reset relations.
// Assumes it is bound to pbsp_port and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module pbsp_port_props (
  // Clock and controls
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clock_gate_n_i,
  input wire logic sleep_request_i,
  input wire logic advance_or_load_i,
  input wire logic read_write_n_i,
  input wire pbsp_pkg::pbsp_sel_t select_i,
  input wire logic output_enable_n_i,
  input wire logic trst_n_i,
  // Observed outputs
  input wire logic [pbsp_pkg::DATA_BITS_W-1:0] data_bits_o,
  input wire logic [pbsp_pkg::EXTRA_W-1:0] byte_extra_bits_o,
  input wire logic data_oe_o,
  input wire logic tdo_oe_o
);
  wire logic act = !clock_gate_n_i && !sleep_request_i;
  wire logic sel = !select_i.chip_select_low_a_n && !select_i.chip_select_low_b_n
    && select_i.chip_select_pair_other;
  wire logic ld = act && !advance_or_load_i;
  wire logic step = act && advance_or_load_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_two: assert property (ld && sel && read_write_n_i ##1 act ##1 act ##1
    !output_enable_n_i |-> data_oe_o) else $error("read data late");
  a_burst_next: assert property (ld && sel && read_write_n_i ##1 step ##1 act ##1 act
    ##1 !output_enable_n_i |-> data_oe_o) else $error("burst word missing");
  a_write_float: assert property (ld && sel && !read_write_n_i ##1 act ##1 act
    |=> !data_oe_o) else $error("bus driven in write slot");
  a_desel_float: assert property (ld && !sel ##1 act ##1 act |=> !data_oe_o)
    else $error("bus driven after deselect");
  a_desel_end: assert property (ld && !sel ##1 step ##1 act ##1 act |=> !data_oe_o)
    else $error("burst went on after deselect");
  a_oe_async: assert property (output_enable_n_i |-> !data_oe_o)
    else $error("bus driven with enable high");
  a_gate_hold: assert property (!act |=> $stable(data_bits_o)
    && $stable(byte_extra_bits_o)) else $error("outputs moved on ignored edge");
  a_reset_zero: assert property (disable iff (1'h0) !rst_n_i |=> !data_oe_o
    && data_bits_o == '0) else $error("outputs not cleared by reset");
  a_tap_quiet: assert property (disable iff (1'h0) !trst_n_i |-> !tdo_oe_o)
    else $error("test output enabled in reset");
  c_read: cover property (ld && sel && read_write_n_i ##1 step);
  c_write: cover property (ld && sel && !read_write_n_i ##1 step);
  c_desel: cover property (ld && !sel ##1 step);
endmodule : pbsp_port_props
bind pbsp_port pbsp_port_props pbsp_port_props_i (.clk_i, .rst_n_i, .clock_gate_n_i,
  .sleep_request_i, .advance_or_load_i, .read_write_n_i, .select_i, .output_enable_n_i,
  .trst_n_i, .data_bits_o, .byte_extra_bits_o, .data_oe_o, .tdo_oe_o);
`default_nettype wire

// ---- pbsp_ctl_model.sv ----
// Controller-side write data stage: shows each write word two active edges after its slot.
// Assumes the bench marks write slots and the edges that the port does not ignore.
`timescale 1ns/100ps
`default_nettype none
module pbsp_ctl_model (
  // Clock and slot marks
  input wire logic clk_i,
  input wire logic active_i,
  input wire logic wr_i,
  input wire logic [35:0] wd_i,
  // Data toward the port
  output logic [31:0] data_bits_o,
  output logic [3:0] extra_o
);
  logic [36:0] s1_q = '0;
  logic [36:0] s2_q = '0;
  logic [35:0] last_q = '0;
  always_ff @(posedge clk_i) begin
    if (active_i) begin
      s1_q <= {wr_i, wd_i};
      s2_q <= s1_q;
      if (s2_q[36]) last_q <= s2_q[35:0];
    end
  end
  // Released bus shows the inverse of the last word
  assign {extra_o, data_bits_o} = s2_q[36] ? s2_q[35:0] : ~last_q;
endmodule : pbsp_ctl_model
`default_nettype wire

// ---- tb_top.sv ----
// Bench for the burst SRAM port: bursts in both orders, masks, deselects, ignored edges.
// Assumes the controller model supplies write data; test pins held in reset until the identification reads.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam pbsp_pkg::pbsp_sel_t SEL = 3'h1;
  logic clk = 1'h0, rst_n = 1'h0, cg_n = 1'h0, slp = 1'h0, burst_order_select_n = 1'h0, adv = 1'h1;
  logic rw = 1'h1, oe_n = 1'h0, wr = 1'h0, trst_n = 1'h1;
  logic tck = 1'h0, tms = 1'h1, tdi = 1'h1, tdo, tdoe;
  pbsp_pkg::pbsp_sel_t sel = 3'h7;
  logic [16:0] addr = '0;
  logic [3:0] bwn = '0, xin, xout;
  logic [35:0] wd = '0;
  logic [31:0] din, dout;
  logic doe;
  logic [35:0] exp_q[$];
  logic [35:0] shadow[int];
  int bad_count = 0, comparisons = 0;
  always #50 clk = ~clk;
  pbsp_port pbsp_port_i (.clk_i(clk), .rst_n_i(rst_n), .clock_gate_n_i(cg_n),
    .sleep_request_i(slp), .burst_order_select_n_i(burst_order_select_n), .advance_or_load_i(adv),
    .read_write_n_i(rw), .select_i(sel), .addr_i(addr), .byte_write_select_n_i(bwn),
    .output_enable_n_i(oe_n), .data_bits_i(din), .byte_extra_bits_i(xin),
    .data_bits_o(dout), .byte_extra_bits_o(xout), .data_oe_o(doe), .tck_i(tck),
    .trst_n_i(trst_n), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdoe));
  pbsp_ctl_model pbsp_ctl_model_i (.clk_i(clk), .active_i(!cg_n && !slp), .wr_i(wr),
    .wd_i(wd), .data_bits_o(din), .extra_o(xin));
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
      input logic [3:0] bw);
    for (int b = 0; b < 4; b++) begin
      if (!bw[b]) begin
        o[8*b +: 8] = n[8*b +: 8];
        o[32+b] = n[32+b];
      end
    end
    return o;
  endfunction : merge
  // One cycle at the pins, sometimes preceded by an ignored edge with junk on the inputs
  task automatic cyc(input logic a, input logic r, input pbsp_pkg::pbsp_sel_t s,
      input logic [16:0] ad, input logic [3:0] bw, input logic [35:0] d, input logic w);
    #1;
    if ($urandom % 4 == 0) begin
      cg_n = 1'($urandom);
      {slp, oe_n, adv, addr} = {!cg_n, 19'($urandom)};
      @(posedge clk);
      #1;
    end
    {cg_n, slp, oe_n} = 3'h0;
    {adv, rw, sel, addr, bwn, wd, wr} = {a, r, s, ad, bw, d, w};
    @(posedge clk);
  endtask : cyc
  task automatic burst(input logic r, input logic [16:0] base, input logic full);
    logic [16:0] ad;
    logic [35:0] d;
    logic [3:0] bw;
    for (int k = 0; k < 4; k++) begin
      ad = {base[16:2], burst_order_select_n ? base[1:0] ^ 2'(k) : base[1:0] + 2'(k)};
      d = 36'($urandom) ^ (36'($urandom) << 4);
      bw = full ? 4'h0 : 4'($urandom);
      if (r) exp_q.push_back(shadow[ad]);
      else shadow[ad] = merge(shadow[ad], d, bw);
      cyc(k != 0, r, SEL, k == 0 ? base : 17'($urandom), bw, d, !r);
    end
  endtask : burst
  // One test clock period: sample the output set by the last fall, then drive and pulse
  task automatic tap_cyc(input logic m, output logic so, output logic soe);
    #1;
    {so, soe} = {tdo, tdoe};
    {tms, tdi} = {m, 1'($urandom)};
    #49 tck = 1'h1;
    #50 tck = 1'h0;
  endtask : tap_cyc
  always @(posedge clk) begin : watch
    logic a;
    a = !cg_n && !slp && rst_n;
    #0.5;
    if (a && doe === 1'h1) begin
      if (exp_q.size() == 0) check({35'h0, doe}, 36'h0);
      else check({xout, dout}, exp_q.pop_front());
    end
  end
  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end
  initial begin : main
    logic [16:0] base;
    pbsp_pkg::pbsp_sel_t ds;
    logic [31:0] id;
    logic so, soe, oe_all;
    void'($urandom(68203));
    #1 trst_n = 1'h0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'h1;
    @(posedge clk);
    for (int o = 0; o < 2; o++) begin
      if (o != 0) begin
        // Burst order only changes while the port is held in reset
        #1 {rst_n, burst_order_select_n} = {1'h0, o[0]};
        repeat (2) @(posedge clk);
        #1 rst_n = 1'h1;
        @(posedge clk);
      end
      base = 17'($urandom);
      burst(1'h0, base, 1'h1);
      burst(1'h0, base, 1'h0);
      burst(1'h1, base, 1'h0);
      for (int j = 0; j < 3; j++) begin
        ds = pbsp_pkg::pbsp_sel_t'(3'h1 ^ (3'h1 << j));
        exp_q.push_back(shadow[base]);
        cyc(1'h0, 1'h1, SEL, base, 4'h0, '0, 1'h0);
        cyc(1'h0, 1'h1, ds, base, 4'h0, '0, 1'h0);
        repeat (2) cyc(1'h1, 1'h1, ds, base, 4'h0, '0, 1'h0);
      end
      $display("order %0d tests done", o);
    end
    repeat (4) cyc(1'h0, 1'h1, ds, base, 4'h0, '0, 1'h0);
    check(36'(exp_q.size()), 36'h0);
    // Identification read after the reset pin, then again after five mode-select highs
    #1 trst_n = 1'h1;
    for (int t = 0; t < 2; t++) begin
      oe_all = 1'h1;
      tap_cyc(1'h0, so, soe);
      tap_cyc(1'h1, so, soe);
      repeat (2) tap_cyc(1'h0, so, soe);
      for (int k = 0; k < 32; k++) begin
        tap_cyc(k == 31, id[k], soe);
        oe_all &= soe;
      end
      tap_cyc(1'h1, so, soe);
      check(36'({oe_all, soe}), 36'h2);
      repeat (4) tap_cyc(1'h1, so, soe);
      check(36'(id), 36'(pbsp_pkg::ID_VALUE));
    end
    $display("tap tests done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
